// ===== pkg/asq_pkg.sv
package asq_pkg;
  // Converter and channel geometry.
  localparam int NCONV = 2;
  localparam int NCH   = 9;
  localparam int CHW   = 4;
  localparam int EXW   = 3;
  localparam int RESW  = 10;
  localparam int VALW  = 12;
  localparam int NRES  = 8;
  localparam int RIW   = 3;
  localparam int QDEP  = 4;
  localparam int QCW   = 3;
  localparam int NEV   = 8;
  localparam int NST   = 6;
  localparam int LSB8  = 2;
  localparam int SMPW  = 8;
  localparam int BITW  = 4;
  localparam int NLANE = 4;
  localparam int LANEW = 8;
  localparam int AW    = 8;
  typedef logic [CHW-1:0]     ch_t;
  typedef logic [CHW+EXW-1:0] req_t;
  typedef logic [VALW-1:0]    val_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_INS, SRC_PAR, SRC_QUE} src_t;
  // Register byte offsets; per-converter registers follow at REG_STRIDE.
  localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AW-1:0] OFS_TIME   = 8'h04;
  localparam logic [AW-1:0] OFS_PRIO   = 8'h08;
  localparam logic [AW-1:0] OFS_TRIG   = 8'h0c;
  localparam logic [AW-1:0] OFS_CMD    = 8'h10;
  localparam logic [AW-1:0] OFS_STAT   = 8'h14;
  localparam logic [AW-1:0] OFS_MASK   = 8'h18;
  localparam logic [AW-1:0] OFS_LIMIT  = 8'h1c;
  localparam logic [AW-1:0] OFS_PAR    = 8'h20;
  localparam logic [AW-1:0] OFS_QUE    = 8'h28;
  localparam logic [AW-1:0] OFS_INS    = 8'h30;
  localparam logic [AW-1:0] OFS_RCFG   = 8'h38;
  localparam logic [AW-1:0] OFS_BWD    = 8'h40;
  localparam logic [AW-1:0] OFS_RES    = 8'h80;
  localparam logic [AW-1:0] REG_STRIDE = 8'h04;
  localparam logic [AW-1:0] RES_BANK   = 8'h20;
  // Field positions and reset values.
  localparam int CTRLW = 5;
  localparam int CTRL_MODE8 = 0;
  localparam int CTRL_APD = 2;
  localparam int CTRL_SYNC = 3;
  localparam int CTRL_MTEST = 4;
  localparam int TIME_BIT_LSB = 8;
  localparam logic [11:0] TIME_RST = 12'h304;
  localparam int PRIO_QUE_LSB = 2;
  localparam logic [3:0] PRIO_RST = 4'h4;
  localparam int TRIG_QUE_LSB = 8;
  localparam int CMD_PAR = 0;
  localparam int CMD_QUE = 2;
  localparam int CMD_FLUSH = 4;
  localparam int ST_RES = 0;
  localparam int ST_LIM = 2;
  localparam int ST_SEQ = 4;
  localparam int LIM_HI_LSB = 16;
  localparam int RCFGW = 13;
  localparam int RC_FIFO = 8;
  localparam int RC_RED_LSB = 9;
  localparam int RC_ACC_LSB = 11;
  localparam logic [1:0] RED_LIMIT = 2'h1;
  localparam logic [1:0] RED_ACC = 2'h2;
  localparam int RD_CH_LSB = 12;
  localparam int RD_VLD = 16;
endpackage

// ===== hdl/adc_sar_engine.sv
`timescale 1ns/1ps
module adc_sar_engine (
  // Clock and control.
  input  wire logic                          i_clk,
  input  wire logic                          i_reset,
  input  wire logic                          i_ce,
  input  wire logic                          i_start,
  input  wire logic                          i_mode8,
  input  wire logic [asq_pkg::SMPW-1:0]      i_smp,
  input  wire logic [asq_pkg::BITW-1:0]      i_bitc,
  // Comparator pin.
  input  wire logic                          i_cmp_pin,
  // Analog control and result.
  output logic                               o_busy,
  output logic                               o_done,
  output logic                               o_sample,
  output logic [asq_pkg::RESW-1:0]           o_dac
);
  typedef enum logic [1:0] {S_IDLE, S_SMP, S_CONV} est_t;
  typedef struct packed {
    est_t                     st;
    logic [asq_pkg::SMPW-1:0] cnt;
    logic [asq_pkg::BITW-1:0] bitn;
    logic [asq_pkg::RESW-1:0] sar;
    logic [2:0]               sync;
    logic                     cmp;
    logic                     done;
    logic                     busy;
    logic                     smp;
  } eng_t;
  eng_t q;
  eng_t d;

  always_comb begin
    d = q;
    d.done = 1'b0;
    // The comparator only counts once the second and third stages agree.
    d.sync = {q.sync[1:0], i_cmp_pin};
    if (q.sync[2] == q.sync[1]) begin
      d.cmp = q.sync[2];
    end
    case (q.st)
      S_IDLE: begin
        if (i_start) begin
          d.st = S_SMP;
          d.cnt = i_smp;
          d.sar = '0;
          d.smp = 1'b1;
          d.busy = 1'b1;
        end
      end
      // [R03] Programmed sample time.
      S_SMP: begin
        if (q.cnt == '0) begin
          d.st = S_CONV;
          d.smp = 1'b0;
          d.bitn = asq_pkg::BITW'(asq_pkg::RESW - 1);
          d.cnt = asq_pkg::SMPW'(i_bitc);
          d.sar[asq_pkg::RESW-1] = 1'b1;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      // [R01] Ten or eight decided bits.
      S_CONV: begin
        if (q.cnt != '0) begin
          d.cnt = q.cnt - 1'b1;
        end else begin
          // The filtered next value keeps comparator latency at three cycles.
          if (!d.cmp) begin
            d.sar[q.bitn] = 1'b0;
          end
          if (q.bitn == (i_mode8 ? asq_pkg::BITW'(asq_pkg::LSB8) : '0)) begin
            d.st = S_IDLE;
            d.done = 1'b1;
            d.busy = 1'b0;
          end else begin
            d.bitn = q.bitn - 1'b1;
            d.sar[q.bitn - 1'b1] = 1'b1;
            d.cnt = asq_pkg::SMPW'(i_bitc);
          end
        end
      end
      default: d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_busy = q.busy;
  assign o_done = q.done;
  assign o_sample = q.smp;
  assign o_dac = q.sar;
endmodule

// ===== hdl/adc_request_sequencer.sv
// Contract
// [R01] Each converter gives 10-bit results, or faster 8-bit results when selected.
// [R02] Two converters exist; two channels are reachable by both of them.
// [R03] Sample time and conversion time are programmable by software.
// [R04] Request sources start from selected trigger events or from software.
// [R05] Parallel source latches all pending channels, converts them lowest first.
// [R06] Queued source converts entries in the order software pushed them.
// [R07] An inserted channel goes next; the running sequence resumes intact.
// [R08] Among pending sources the highest priority level wins the converter.
// [R09] Eight result registers per converter, optionally chained into a FIFO.
// [R10] Per-register wait-for-read keeps a new result from overwriting unread data.
// [R11] Results reduce by limit checking or by accumulation before notifying.
// [R12] Both converters can start in lockstep, sampling at the same moment.
// [R13] External multiplexer select is driven automatically with each conversion.
// [R14] With auto power down the analog part is off while nothing converts; power stays on while a blocked result is held.
// [R15] Per-channel broken-wire detection and a multiplexer test mode exist.
// [R16] A blocked result is held and new requests stall until software reads.
`timescale 1ns/1ps
module adc_request_sequencer (
  // Clock, reset and clock enable.
  input  wire logic                            i_clk,
  input  wire logic                            i_reset,
  input  wire logic                            i_ce,
  // Wishbone classic slave.
  input  wire logic                            i_wb_cyc,
  input  wire logic                            i_wb_stb,
  input  wire logic                            i_wb_we,
  input  wire logic [asq_pkg::AW-1:0]          i_wb_adr,
  input  wire logic [31:0]                     i_wb_dat,
  input  wire logic [3:0]                      i_wb_sel,
  output logic [31:0]                          o_wb_dat,
  output logic                                 o_wb_ack,
  // Trigger events and comparator pins.
  input  wire logic [asq_pkg::NEV-1:0]         i_trig,
  input  wire logic [asq_pkg::NCONV-1:0]       i_cmp,
  // Analog front end control.
  output logic [asq_pkg::NCONV-1:0]            o_sample,
  output logic [asq_pkg::NCONV-1:0][9:0]       o_dac,
  output logic [asq_pkg::NCONV-1:0][3:0]       o_ch_sel,
  output logic [asq_pkg::NCONV-1:0][2:0]       o_ext_mux,
  output logic [asq_pkg::NCONV-1:0]            o_pwr_up,
  output logic [asq_pkg::NCONV-1:0]            o_bwd,
  output logic                                 o_mux_test,
  // Interrupt.
  output logic                                 o_irq
);
  localparam int N = asq_pkg::NCONV;
  typedef struct packed {
    logic                                    ack;
    logic [31:0]                             rdat;
    logic [asq_pkg::CTRLW-1:0]               ctrl;
    logic [11:0]                             tim;
    logic [3:0]                              prio;
    logic [15:0]                             trig;
    logic [asq_pkg::NST-1:0]                 mask;
    logic [asq_pkg::NST-1:0]                 stat;
    logic [31:0]                             lim;
    logic [2:0][asq_pkg::NEV-1:0]            ts;
    logic [asq_pkg::NEV-1:0]                 tstab;
    logic [N-1:0][asq_pkg::NCH-1:0]          pmask;
    logic [N-1:0][asq_pkg::NCH-1:0]          pend;
    logic [N-1:0][asq_pkg::NCH-1:0]          bwd;
    logic [N-1:0][asq_pkg::QDEP-1:0][6:0]    que;
    logic [N-1:0][asq_pkg::QCW-1:0]          qcnt;
    logic [N-1:0]                            qrun;
    logic [N-1:0]                            insv;
    logic [N-1:0][6:0]                       ins;
    logic [N-1:0]                            busy;
    logic [N-1:0]                            hold;
    logic [N-1:0]                            go;
    logic [N-1:0][6:0]                       cur;
    logic [N-1:0][asq_pkg::RCFGW-1:0]        rcfg;
    logic [N-1:0][asq_pkg::NRES-1:0][15:0]   res;
    logic [N-1:0][asq_pkg::NRES-1:0]         rvld;
    logic [N-1:0][asq_pkg::RIW-1:0]          wp;
    logic [N-1:0][asq_pkg::RIW-1:0]          rp;
    logic [N-1:0][asq_pkg::VALW-1:0]         acc;
    logic [N-1:0][1:0]                       acnt;
    logic [N-1:0][3:0]                       ch_o;
    logic [N-1:0][2:0]                       ext_o;
    logic [N-1:0]                            pwr_o;
    logic [N-1:0]                            bwd_o;
    logic                                    mtest_o;
    logic                                    irq_o;
  } st_t;
  st_t q;
  st_t d;

  logic [N-1:0]            eng_busy;
  logic [N-1:0]            eng_done;
  logic [N-1:0][9:0]       eng_res;
  logic                    req;
  logic                    cw;
  logic                    cr;
  logic [31:0]             rdv;
  logic [5:0]              cmd;
  logic [asq_pkg::NEV-1:0] rise;
  logic [N-1:0]            rdy;
  logic [N-1:0]            go;
  asq_pkg::src_t [N-1:0]   src;
  asq_pkg::req_t [N-1:0]   pick;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] m;
    for (int b = 0; b < asq_pkg::NLANE; b++) begin
      m[b*asq_pkg::LANEW +: asq_pkg::LANEW] = {asq_pkg::LANEW{s[b]}};
    end
    return (o & ~m) | (n & m);
  endfunction

  function automatic logic [7:0] radr(input logic [7:0] b, input int k);
    return b + 8'(k) * asq_pkg::REG_STRIDE;
  endfunction

  function automatic asq_pkg::ch_t first_ch(input logic [asq_pkg::NCH-1:0] m);
    first_ch = '0;
    for (int i = asq_pkg::NCH - 1; i >= 0; i--) begin
      if (m[i]) begin
        first_ch = asq_pkg::ch_t'(i);
      end
    end
  endfunction

  // Insertion always wins; a tie between the two sources goes to the parallel one.
  function automatic asq_pkg::src_t arb(input logic iv, input logic pv, input logic qv,
                                        input logic [1:0] pp, input logic [1:0] qp);
    if (iv) begin
      return asq_pkg::SRC_INS;
    end
    if (pv && (!qv || pp >= qp)) begin
      return asq_pkg::SRC_PAR;
    end
    if (qv) begin
      return asq_pkg::SRC_QUE;
    end
    return asq_pkg::SRC_NONE;
  endfunction

  always_comb begin
    logic [asq_pkg::RIW-1:0]  ix;
    logic [asq_pkg::VALW-1:0] val;
    logic [asq_pkg::VALW-1:0] sum;
    logic                     wrn;
    logic                     fifo;
    logic [1:0]               red;
    logic [asq_pkg::RIW-1:0]  ri;
    ix = '0;
    val = '0;
    sum = '0;
    wrn = 1'b0;
    fifo = 1'b0;
    red = '0;
    ri = '0;
    d = q;
    d.go = '0;
    // The answer comes one cycle after the request; side effects happen with the ack.
    req = i_wb_cyc && i_wb_stb && !q.ack;
    cw = i_wb_cyc && i_wb_stb && q.ack && i_wb_we;
    cr = i_wb_cyc && i_wb_stb && q.ack && !i_wb_we;
    rdv = '0;
    case (i_wb_adr)
      asq_pkg::OFS_CTRL:  rdv = 32'(q.ctrl);
      asq_pkg::OFS_TIME:  rdv = 32'(q.tim);
      asq_pkg::OFS_PRIO:  rdv = 32'(q.prio);
      asq_pkg::OFS_TRIG:  rdv = 32'(q.trig);
      asq_pkg::OFS_STAT:  rdv = 32'(q.stat);
      asq_pkg::OFS_MASK:  rdv = 32'(q.mask);
      asq_pkg::OFS_LIMIT: rdv = q.lim;
      default:            rdv = '0;
    endcase
    for (int k = 0; k < N; k++) begin
      if (i_wb_adr == radr(asq_pkg::OFS_PAR, k)) rdv = 32'(q.pmask[k]);
      if (i_wb_adr == radr(asq_pkg::OFS_QUE, k)) rdv = 32'({q.qrun[k], q.qcnt[k]});
      if (i_wb_adr == radr(asq_pkg::OFS_INS, k)) rdv = 32'({q.insv[k], q.ins[k]});
      if (i_wb_adr == radr(asq_pkg::OFS_RCFG, k)) rdv = 32'(q.rcfg[k]);
      if (i_wb_adr == radr(asq_pkg::OFS_BWD, k)) rdv = 32'(q.bwd[k]);
      for (int i = 0; i < asq_pkg::NRES; i++) begin
        if (i_wb_adr == radr(asq_pkg::OFS_RES + 8'(k) * asq_pkg::RES_BANK, i)) begin
          ri = (q.rcfg[k][asq_pkg::RC_FIFO] && i == 0) ? q.rp[k] : asq_pkg::RIW'(i);
          rdv = 32'({q.rvld[k][ri], q.res[k][ri]});
        end
      end
    end
    d.ack = req;
    d.rdat = req ? rdv : '0;

    // Global register writes; a status read clears exactly the bits it returned.
    cmd = '0;
    if (cw) begin
      case (i_wb_adr)
        asq_pkg::OFS_CTRL:  d.ctrl = asq_pkg::CTRLW'(merge(32'(q.ctrl), i_wb_dat, i_wb_sel));
        asq_pkg::OFS_TIME:  d.tim = 12'(merge(32'(q.tim), i_wb_dat, i_wb_sel));
        asq_pkg::OFS_PRIO:  d.prio = 4'(merge(32'(q.prio), i_wb_dat, i_wb_sel));
        asq_pkg::OFS_TRIG:  d.trig = 16'(merge(32'(q.trig), i_wb_dat, i_wb_sel));
        asq_pkg::OFS_MASK:  d.mask = asq_pkg::NST'(merge(32'(q.mask), i_wb_dat, i_wb_sel));
        asq_pkg::OFS_LIMIT: d.lim = merge(q.lim, i_wb_dat, i_wb_sel);
        asq_pkg::OFS_CMD:   cmd = i_wb_dat[5:0] & {6{i_wb_sel[0]}};
        default:            cmd = '0;
      endcase
    end
    if (cr && i_wb_adr == asq_pkg::OFS_STAT) begin
      d.stat = q.stat & ~q.rdat[asq_pkg::NST-1:0];
    end

    // [R04] Trigger events, synchronised, taken on their rising edge.
    d.ts = {q.ts[1:0], i_trig};
    rise = '0;
    for (int e = 0; e < asq_pkg::NEV; e++) begin
      if (q.ts[2][e] == q.ts[1][e]) begin
        d.tstab[e] = q.ts[2][e];
        rise[e] = q.ts[2][e] && !q.tstab[e];
      end
    end

    // [R08] Priority arbitration per converter.
    for (int k = 0; k < N; k++) begin
      src[k] = arb(q.insv[k], q.pend[k] != '0, q.qrun[k] && q.qcnt[k] != '0,
                   q.prio[1:0], q.prio[asq_pkg::PRIO_QUE_LSB +: 2]);
      case (src[k])
        asq_pkg::SRC_INS: pick[k] = q.ins[k];
        asq_pkg::SRC_PAR: pick[k] = asq_pkg::req_t'(first_ch(q.pend[k]));
        asq_pkg::SRC_QUE: pick[k] = q.que[k][0];
        default:          pick[k] = '0;
      endcase
      // [R16] No start while a result is still held.
      rdy[k] = !q.busy[k] && !q.hold[k] && !q.go[k] && !eng_busy[k];
    end
    // [R12] Lockstep start of both converters on the first one's request.
    go[0] = rdy[0] && src[0] != asq_pkg::SRC_NONE &&
            (!q.ctrl[asq_pkg::CTRL_SYNC] || rdy[1]);
    go[1] = q.ctrl[asq_pkg::CTRL_SYNC] ? go[0] : (rdy[1] && src[1] != asq_pkg::SRC_NONE);

    for (int k = 0; k < N; k++) begin
      fifo = q.rcfg[k][asq_pkg::RC_FIFO];
      red = q.rcfg[k][asq_pkg::RC_RED_LSB +: 2];
      // Software access to the per-converter registers.
      if (cw && i_wb_adr == radr(asq_pkg::OFS_PAR, k)) begin
        d.pmask[k] = asq_pkg::NCH'(merge(32'(q.pmask[k]), i_wb_dat, i_wb_sel));
      end
      if (cw && i_wb_adr == radr(asq_pkg::OFS_RCFG, k)) begin
        d.rcfg[k] = asq_pkg::RCFGW'(merge(32'(q.rcfg[k]), i_wb_dat, i_wb_sel));
      end
      // [R15] Broken-wire detection enables per channel.
      if (cw && i_wb_adr == radr(asq_pkg::OFS_BWD, k)) begin
        d.bwd[k] = asq_pkg::NCH'(merge(32'(q.bwd[k]), i_wb_dat, i_wb_sel));
      end
      for (int i = 0; i < asq_pkg::NRES; i++) begin
        if (cr && i_wb_adr == radr(asq_pkg::OFS_RES + 8'(k) * asq_pkg::RES_BANK, i)) begin
          ri = (fifo && i == 0) ? q.rp[k] : asq_pkg::RIW'(i);
          d.rvld[k][ri] = 1'b0;
          if (fifo && i == 0 && q.rvld[k][ri]) begin
            d.rp[k] = q.rp[k] + 1'b1;
          end
        end
      end

      // Grant: consume the request from its source and drive the analog controls.
      if (go[k]) begin
        d.go[k] = 1'b1;
        d.busy[k] = 1'b1;
        d.cur[k] = (q.ctrl[asq_pkg::CTRL_SYNC] && k == 1) ? pick[0] : pick[k];
        // [R13] External multiplexer select follows the granted request.
        d.ch_o[k] = d.cur[k][asq_pkg::CHW-1:0];
        d.ext_o[k] = d.cur[k][6:asq_pkg::CHW];
        d.bwd_o[k] = q.bwd[k][d.cur[k][asq_pkg::CHW-1:0]];
        if (!(q.ctrl[asq_pkg::CTRL_SYNC] && k == 1)) begin
          case (src[k])
            // [R07] Insertion leaves the other sources untouched.
            asq_pkg::SRC_INS: d.insv[k] = 1'b0;
            // [R05] Lowest pending channel goes first.
            asq_pkg::SRC_PAR: begin
              d.pend[k][first_ch(q.pend[k])] = 1'b0;
              if (d.pend[k] == '0) begin
                d.stat[asq_pkg::ST_SEQ + k] = 1'b1;
              end
            end
            // [R06] Queue pops from the head in push order.
            asq_pkg::SRC_QUE: begin
              for (int j = 0; j < asq_pkg::QDEP - 1; j++) begin
                d.que[k][j] = q.que[k][j + 1];
              end
              d.qcnt[k] = q.qcnt[k] - 1'b1;
              if (d.qcnt[k] == '0) begin
                d.qrun[k] = 1'b0;
              end
            end
            default: d.insv[k] = q.insv[k];
          endcase
        end
      end
      // [R05] A trigger latches the whole channel mask at once.
      if (cmd[asq_pkg::CMD_PAR + k] || (rise & q.trig[asq_pkg::NEV-1:0]) != '0) begin
        d.pend[k] = d.pend[k] | q.pmask[k];
      end
      // A push to a full queue is dropped.
      if (cw && i_wb_adr == radr(asq_pkg::OFS_QUE, k) && i_wb_sel[0] &&
          d.qcnt[k] < asq_pkg::QCW'(asq_pkg::QDEP)) begin
        d.que[k][d.qcnt[k][asq_pkg::QCW-2:0]] = i_wb_dat[6:0];
        d.qcnt[k] = d.qcnt[k] + 1'b1;
      end
      if (cmd[asq_pkg::CMD_QUE + k] || (rise & q.trig[asq_pkg::TRIG_QUE_LSB +: 8]) != '0) begin
        d.qrun[k] = 1'b1;
      end
      if (cmd[asq_pkg::CMD_FLUSH + k]) begin
        d.qcnt[k] = '0;
        d.qrun[k] = 1'b0;
      end
      if (cw && i_wb_adr == radr(asq_pkg::OFS_INS, k) && i_wb_sel[0]) begin
        d.ins[k] = i_wb_dat[6:0];
        d.insv[k] = 1'b1;
      end

      // Result store, on completion or while a held result retries.
      if (eng_done[k] || q.hold[k]) begin
        // [R09] FIFO chaining or channel-addressed result register.
        ix = fifo ? q.wp[k] : q.cur[k][asq_pkg::RIW-1:0];
        val = asq_pkg::VALW'(eng_res[k]);
        sum = q.acc[k] + val;
        wrn = red != asq_pkg::RED_ACC || q.acnt[k] == q.rcfg[k][asq_pkg::RC_ACC_LSB +: 2];
        // [R10] Wait-for-read blocks an unread register.
        if (wrn && d.rvld[k][ix] && (fifo || q.rcfg[k][ix])) begin
          d.hold[k] = 1'b1;
        end else begin
          d.hold[k] = 1'b0;
          d.busy[k] = 1'b0;
          d.bwd_o[k] = 1'b0;
          // [R11] Accumulation or limit checking.
          if (red == asq_pkg::RED_ACC) begin
            d.acc[k] = wrn ? '0 : sum;
            d.acnt[k] = wrn ? '0 : q.acnt[k] + 1'b1;
            val = sum;
          end
          if (red == asq_pkg::RED_LIMIT &&
              (val < q.lim[asq_pkg::VALW-1:0] || val > q.lim[asq_pkg::LIM_HI_LSB +: 12])) begin
            d.stat[asq_pkg::ST_LIM + k] = 1'b1;
          end
          if (wrn) begin
            d.res[k][ix] = {q.cur[k][asq_pkg::CHW-1:0], val};
            d.rvld[k][ix] = 1'b1;
            d.stat[asq_pkg::ST_RES + k] = 1'b1;
            if (fifo) begin
              d.wp[k] = q.wp[k] + 1'b1;
            end
          end
        end
      end
      // [R14] Analog part powered only around a conversion when auto power down is set.
      d.pwr_o[k] = !d.ctrl[asq_pkg::CTRL_APD] || d.busy[k];
    end
    // [R15] Multiplexer test mode.
    d.mtest_o = d.ctrl[asq_pkg::CTRL_MTEST];
    d.irq_o = (d.stat & d.mask) != '0;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q <= '0;
      q.tim <= asq_pkg::TIME_RST;
      q.prio <= asq_pkg::PRIO_RST;
      q.pwr_o <= '1;
    end else if (i_ce) begin
      q <= d;
    end
  end

  // [R02] Two converter instances.
  for (genvar k = 0; k < N; k++) begin : g_conv
    adc_sar_engine u_eng (
      .i_clk     (i_clk),
      .i_reset   (i_reset),
      .i_ce      (i_ce),
      .i_start   (q.go[k]),
      .i_mode8   (q.ctrl[asq_pkg::CTRL_MODE8 + k]),
      .i_smp     (q.tim[asq_pkg::SMPW-1:0]),
      .i_bitc    (q.tim[asq_pkg::TIME_BIT_LSB +: asq_pkg::BITW]),
      .i_cmp_pin (i_cmp[k]),
      .o_busy    (eng_busy[k]),
      .o_done    (eng_done[k]),
      .o_sample  (o_sample[k]),
      .o_dac     (o_dac[k])
    );
    assign eng_res[k] = o_dac[k];
  end

  assign o_wb_dat = q.rdat;
  assign o_wb_ack = q.ack;
  assign o_ch_sel = q.ch_o;
  assign o_ext_mux = q.ext_o;
  assign o_pwr_up = q.pwr_o;
  assign o_bwd = q.bwd_o;
  assign o_mux_test = q.mtest_o;
  assign o_irq = q.irq_o;
endmodule

// ===== dv/asq_analog.sv
`timescale 1ns/1ps
module asq_analog (
  // Converter side.
  input  wire logic [1:0][9:0] i_dac,
  input  wire logic [1:0][3:0] i_ch_sel,
  // Comparator answers.
  output logic [1:0]           o_cmp
);
  // Each channel carries a fixed level, so every result is known in advance.
  // shared channel levels
  assign o_cmp[0] = {i_ch_sel[0], 6'h2a} >= i_dac[0];
  assign o_cmp[1] = {i_ch_sel[1], 6'h2a} >= i_dac[1];
endmodule

// ===== dv/asq_properties.sv
`timescale 1ns/1ps
module asq_properties (
  // Clock, reset and bus.
  input wire logic            i_clk,
  input wire logic            i_reset,
  input wire logic            i_ce,
  input wire logic            i_wb_cyc,
  input wire logic            i_wb_stb,
  input wire logic [31:0]     o_wb_dat,
  input wire logic            o_wb_ack,
  // Front end.
  input wire logic [1:0]      o_sample,
  input wire logic [1:0]      o_pwr_up,
  input wire logic [1:0][3:0] o_ch_sel,
  input wire logic [1:0][2:0] o_ext_mux
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // The sample length assumes the reset timing setting is kept.
  sequence s_take;
    i_wb_cyc && i_wb_stb && !o_wb_ack && i_ce;
  endsequence
  sequence s_samp;
    o_sample[0] [*5] ##1 !o_sample[0];
  endsequence
  ack_take_a: assert property (s_take |=> o_wb_ack) else $error("no ack");
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("long ack");
  rdat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("dat");
  samp_len_a: assert property ($rose(o_sample[0]) |-> s_samp) else $error("sample");
  samp_pwr_a: assert property ((o_sample & ~o_pwr_up) == 2'h0) else $error("power");
  ch_range_a: assert property (o_ch_sel[0] <= 4'h8) else $error("channel");
  mux_hold_a: assert property (o_sample[0] && $past(o_sample[0]) |-> $stable(o_ext_mux[0]))
    else $error("mux moved");
  chan_hold_a: assert property ($rose(o_sample[1]) |=> $stable(o_ch_sel[1]) throughout
    o_sample[1] [*4]) else $error("channel moved");
endmodule
bind adc_request_sequencer asq_properties chk_u (.i_clk, .i_reset, .i_ce, .i_wb_cyc, .i_wb_stb,
  .o_wb_dat, .o_wb_ack, .o_sample, .o_pwr_up, .o_ch_sel, .o_ext_mux);

// ===== dv/tb.sv
`timescale 1ns/1ps
`define CK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL %s exp %h got %h", n, e, g); end end
module tb;
  logic            i_clk, i_reset, i_ce, cyc, stb, we, ack, irq, mtest;
  logic [7:0]      adr, trig;
  logic [31:0]     dat, rd, rdat;
  logic [1:0]      cmp, smp, pwr, bwd;
  logic [1:0][9:0] dac;
  logic [1:0][2:0] ext;
  logic [1:0][3:0] chs;
  int              err_total, tests_run, cyc_n, k;
  adc_request_sequencer dut_u (.i_clk, .i_reset, .i_ce, .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(4'hf), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_trig(trig), .i_cmp(cmp), .o_sample(smp), .o_dac(dac), .o_ch_sel(chs),
    .o_ext_mux(ext), .o_pwr_up(pwr), .o_bwd(bwd), .o_mux_test(mtest), .o_irq(irq));
  asq_analog ana_u (.i_dac(dac), .i_ch_sel(chs), .o_cmp(cmp));
  initial begin
    i_clk = 1'h0;
    forever #2 i_clk = ~i_clk;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // The run needs under 2000 cycles, so this ceiling only cuts a hang.
  always @(posedge i_clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_total++;
      end_of_test();
    end
  end
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {cyc, stb, we, adr, dat} <= {2'h3, w, a, d};
    do @(posedge i_clk); while (ack !== 1'h1);
    rd = rdat;
    {cyc, stb} <= 2'h0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'h1, a, d);
  endtask
  task rk(input logic [7:0] a, input logic [31:0] e, input string n);
    wb(1'h0, a, 32'h0);
    `CK(n, e, rd)
  endtask
  task irq_is(input logic e, input int lim);
    repeat (2) @(posedge i_clk);
    for (k = 0; k < lim && irq !== e; k++) @(posedge i_clk);
    `CK("irq", e, irq)
  endtask
  function logic [31:0] res(input logic [3:0] c);
    return {15'h0, 1'h1, c, 2'h0, c, 6'h2a};
  endfunction
  initial begin
    {i_reset, i_ce, cyc, stb, we, adr, dat, trig} = {2'h3, 51'h0};
    repeat (16) @(posedge i_clk);
    i_reset <= 1'h0;
    rk(8'h04, 32'h304, "time");
    rk(8'h08, 32'h4, "prio");
    rk(8'h7c, 32'h0, "unmapped");
    $display("test reset done");
    wr(8'h38, 32'h100);
    wr(8'h0c, 32'h1);
    wr(8'h20, 32'ha);
    wr(8'h18, 32'h10);
    trig <= 8'h1;
    irq_is(1'h1, 900);
    trig <= 8'h0;
    wr(8'h18, 32'h0);
    irq_is(1'h0, 0);
    wr(8'h18, 32'h10);
    irq_is(1'h1, 0);
    rk(8'h14, 32'h11, "stat");
    irq_is(1'h0, 0);
    // The second channel is still converting, so wait for its result flag.
    wr(8'h18, 32'h1);
    irq_is(1'h1, 900);
    rk(8'h80, res(4'h1), "pop first");
    rk(8'h80, res(4'h3), "pop second");
    rk(8'h14, 32'h1, "stat");
    $display("test parallel done");
    wr(8'h28, 32'h25);
    wr(8'h28, 32'h32);
    wr(8'h10, 32'h4);
    irq_is(1'h1, 900);
    rk(8'h14, 32'h1, "stat");
    irq_is(1'h1, 900);
    rk(8'h80, res(4'h5), "queue first");
    rk(8'h80, res(4'h2), "queue second");
    rk(8'h80, 32'h0, "fifo empty");
    rk(8'h14, 32'h1, "stat");
    wr(8'h00, 32'h14);
    @(posedge i_clk);
    `CK("mux test", 1'h1, mtest)
    `CK("power down", 2'h0, pwr)
    `CK("ext mux", 3'h3, ext[0])
    $display("test queue done");
    wr(8'h40, 32'h80);
    wr(8'h00, 32'he);
    wr(8'h20, 32'h80);
    wr(8'h10, 32'h1);
    for (k = 0; k < 300 && smp[0] !== 1'h1; k++) @(posedge i_clk);
    `CK("lockstep", 2'h3, smp)
    `CK("shared chan", 4'h7, chs[1])
    `CK("broken wire", 2'h1, bwd)
    `CK("power up", 2'h3, pwr)
    irq_is(1'h1, 900);
    rk(8'hbc, res(4'h7) & ~32'h3, "eight bit");
    rk(8'h80, res(4'h7), "ten bit");
    $display("test lockstep done");
    end_of_test();
  end
endmodule
